// [rtl/ocrs_top.sv]
`timescale 1ns/1ns
`include "ocrs_defines.svh"
module ocrs_top (
  // Clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources, asynchronous levels
  input  wire logic        pin_reset_in,
  input  wire logic        wdt_reset_in,
  input  wire logic        bod_reset_in,
  input  wire logic        sw_reset_in,
  // System oscillator controls
  output logic             osc_bypass,
  output logic             osc_range_choice,
  // Watchdog oscillator controls
  output logic      [4:0]  wdosc_div_code,
  output logic      [3:0]  wdosc_freq_code,
  output logic      [6:0]  wdosc_div_ratio,
  // RC oscillator trim
  output logic      [7:0]  rc_osc_trim,
  // Applied PLL input source
  output ocrs_pkg::ocrs_pll_src_t pll_src_sel,
  // Interrupt
  output logic             irq
);

  // Register state
  logic [1:0]              sysosc_reg;
  logic [1:0]              sysosc_next;
  logic [4:0]              wddiv_reg;
  logic [4:0]              wddiv_next;
  logic [3:0]              wdfreq_reg;
  logic [3:0]              wdfreq_next;
  logic [7:0]              trim_reg;
  logic [7:0]              trim_next;
  logic [4:0]              cause_reg;
  logic [4:0]              cause_next;
  ocrs_pkg::ocrs_pll_src_t pllsrc_reg;
  ocrs_pkg::ocrs_pll_src_t pllsrc_next;
  logic                    upd_reg;
  logic                    upd_next;
  logic                    upd_prev_reg;
  ocrs_pkg::ocrs_pll_src_t applied_reg;
  ocrs_pkg::ocrs_pll_src_t applied_next;
  logic [2:0]              irq_stat_reg;
  logic [2:0]              irq_stat_next;
  logic [2:0]              irq_mask_reg;
  logic [2:0]              irq_mask_next;
  logic [31:0]             prdata_reg;
  logic [31:0]             prdata_next;
  logic [3:0]              src_prev_reg;

  // Bus decode wires
  wire logic               setup_phase;
  wire logic               access_phase;
  wire logic               wr_en;
  wire logic               addr_hit;
  ocrs_pkg::ocrs_reg_e     reg_sel;

  // Reset source wires
  wire logic [3:0]         src_async;
  wire logic [3:0]         src_sync;
  wire logic [3:0]         src_rise;
  wire logic [4:0]         cause_set;
  wire logic [4:0]         cause_clr;

  // Update and event wires
  wire logic               upd_rise;
  wire logic [2:0]         events;
  wire logic [2:0]         irq_clr;

  // Read words, reserved bits zero
  wire logic [31:0]        rdw_sysosc;
  wire logic [31:0]        rdw_wdosc;
  wire logic [31:0]        rdw_trim;
  wire logic [31:0]        rdw_cause;
  wire logic [31:0]        rdw_pllsrc;
  wire logic [31:0]        rdw_upd;
  wire logic [31:0]        rdw_irqstat;
  wire logic [31:0]        rdw_irqmask;

  // Source order matches cause bits 1..4
  assign src_async = {sw_reset_in, bod_reset_in,
                      wdt_reset_in, pin_reset_in};

  // Two-stage synchroniser for the reset source levels; the chain
  // resets low, so a source held through power-on shows up as a rise
  // two edges after release
  ocrs_sync #(
    .WIDTH (4)
  ) u_src_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (src_async),
    .sync_out (src_sync)
  );

  // APB phases; every access completes without wait states.
  // Read data is caught in setup, so a read right after a write sees
  // the new value: the write lands at the access edge before it
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready       = 1'b1;

  // Address decode
  assign reg_sel =
    (paddr == `OCRS_ADDR_SYSOSC)   ? ocrs_pkg::OCRS_R_SYSOSC   :
    (paddr == `OCRS_ADDR_WDOSC)    ? ocrs_pkg::OCRS_R_WDOSC    :
    (paddr == `OCRS_ADDR_TRIM)     ? ocrs_pkg::OCRS_R_TRIM     :
    (paddr == `OCRS_ADDR_RSTCAUSE) ? ocrs_pkg::OCRS_R_RSTCAUSE :
    (paddr == `OCRS_ADDR_PLLSRC)   ? ocrs_pkg::OCRS_R_PLLSRC   :
    (paddr == `OCRS_ADDR_PLLUPD)   ? ocrs_pkg::OCRS_R_PLLUPD   :
    (paddr == `OCRS_ADDR_IRQSTAT)  ? ocrs_pkg::OCRS_R_IRQSTAT  :
    (paddr == `OCRS_ADDR_IRQMASK)  ? ocrs_pkg::OCRS_R_IRQMASK  :
                                     ocrs_pkg::OCRS_R_NONE;

  // Unmapped addresses answer with an error and change nothing
  assign addr_hit = (reg_sel != ocrs_pkg::OCRS_R_NONE);
  assign pslverr  = access_phase & ~addr_hit;
  assign wr_en    = access_phase & pwrite & addr_hit;

  // System oscillator control, two live bits only
  assign sysosc_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_SYSOSC) ?
      pwdata[1:0] : sysosc_reg;

  // Watchdog oscillator control fields
  assign wddiv_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_WDOSC) ?
      pwdata[`OCRS_WDOSC_DIV_MSB:`OCRS_WDOSC_DIV_LSB] :
      wddiv_reg;
  assign wdfreq_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_WDOSC) ?
      pwdata[`OCRS_WDOSC_FREQ_MSB:`OCRS_WDOSC_FREQ_LSB] :
      wdfreq_reg;

  // RC oscillator trim
  assign trim_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_TRIM) ?
      pwdata[7:0] : trim_reg;

  // PLL source code, stored but not yet applied
  assign pllsrc_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_PLLSRC) ?
      pwdata[1:0] : pllsrc_reg;

  // Update bit; writing one while it is already one is no toggle,
  // so software must write zero first
  assign upd_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_PLLUPD) ?
      pwdata[`OCRS_UPD_BIT] : upd_reg;

  // Low-to-high toggle of the update bit
  assign upd_rise = upd_reg & ~upd_prev_reg;

  // Applied selection holds until the toggle
  assign applied_next = upd_rise ? pllsrc_reg : applied_reg;

  // Reset cause: a source level held high sets its bit, even right
  // after power-on, so a pin still held past release is recorded
  assign cause_set = {src_sync, 1'b0};

  // Write-one-to-clear of the cause bits
  assign cause_clr =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_RSTCAUSE) ?
      pwdata[4:0] : 5'h00;

  // Set wins over a clear in the same cycle
  assign cause_next = (cause_reg & ~cause_clr) | cause_set;

  // Rising edges of reset sources for the interrupt
  assign src_rise = src_sync & ~src_prev_reg;

  // Interrupt events; the reserved code is passed on unchanged and
  // only flagged, so a later update can recover from it
  assign events[`OCRS_EV_SWITCHED] = upd_rise;
  assign events[`OCRS_EV_RSTSEEN]  = |src_rise;
  assign events[`OCRS_EV_RSVDSRC]  = upd_rise & (&pllsrc_reg);

  // Interrupt status write-one-to-clear, set wins
  assign irq_clr =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_IRQSTAT) ?
      pwdata[2:0] : 3'h0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | events;

  // Interrupt mask
  assign irq_mask_next =
    (wr_en && reg_sel == ocrs_pkg::OCRS_R_IRQMASK) ?
      pwdata[2:0] : irq_mask_reg;

  // Read words of each register; reserved bits read zero
  assign rdw_sysosc  = {30'h0000_0000, sysosc_reg};
  assign rdw_wdosc   = {23'h00_0000, wdfreq_reg, wddiv_reg};
  assign rdw_trim    = {24'h00_0000, trim_reg};
  assign rdw_cause   = {27'h000_0000, cause_reg};
  assign rdw_pllsrc  = {30'h0000_0000, pllsrc_reg};
  assign rdw_upd     = {31'h0000_0000, upd_reg};
  assign rdw_irqstat = {29'h0000_0000, irq_stat_reg};
  assign rdw_irqmask = {29'h0000_0000, irq_mask_reg};

  // Read data is caught in the setup phase; reserved bits are zero
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_phase && !pwrite) begin
      if (reg_sel == ocrs_pkg::OCRS_R_SYSOSC) begin
        prdata_next = rdw_sysosc;
      end else if (reg_sel == ocrs_pkg::OCRS_R_WDOSC) begin
        prdata_next = rdw_wdosc;
      end else if (reg_sel == ocrs_pkg::OCRS_R_TRIM) begin
        prdata_next = rdw_trim;
      end else if (reg_sel == ocrs_pkg::OCRS_R_RSTCAUSE) begin
        prdata_next = rdw_cause;
      end else if (reg_sel == ocrs_pkg::OCRS_R_PLLSRC) begin
        prdata_next = rdw_pllsrc;
      end else if (reg_sel == ocrs_pkg::OCRS_R_PLLUPD) begin
        prdata_next = rdw_upd;
      end else if (reg_sel == ocrs_pkg::OCRS_R_IRQSTAT) begin
        prdata_next = rdw_irqstat;
      end else if (reg_sel == ocrs_pkg::OCRS_R_IRQMASK) begin
        prdata_next = rdw_irqmask;
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  // Oscillator setting registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sysosc_reg <= `OCRS_RST_SYSOSC;
      wddiv_reg  <= `OCRS_RST_WDDIV;
      wdfreq_reg <= `OCRS_RST_WDFREQ;
      trim_reg   <= `OCRS_RST_TRIM;
    end else begin
      sysosc_reg <= sysosc_next;
      wddiv_reg  <= wddiv_next;
      wdfreq_reg <= wdfreq_next;
      trim_reg   <= trim_next;
    end
  end

  // Reset cause; rst is the power-on reset of this block
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause_reg    <= `OCRS_RST_CAUSE;
      src_prev_reg <= 4'h0;
    end else begin
      cause_reg    <= cause_next;
      src_prev_reg <= src_sync;
    end
  end

  // PLL source selection and its update bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pllsrc_reg   <= `OCRS_RST_PLLSRC;
      upd_reg      <= `OCRS_RST_UPD;
      upd_prev_reg <= `OCRS_RST_UPD;
      applied_reg  <= `OCRS_RST_PLLSRC;
    end else begin
      pllsrc_reg   <= pllsrc_next;
      upd_reg      <= upd_next;
      upd_prev_reg <= upd_reg;
      applied_reg  <= applied_next;
    end
  end

  // Interrupt registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= `OCRS_RST_IRQ;
      irq_mask_reg <= `OCRS_RST_IRQ;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Read data register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // Interrupt output, level
  // Uses next values, so irq drops in the cycle the status is cleared
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_next & irq_mask_next);
    end
  end

  // Oscillator control outputs
  assign osc_bypass       = sysosc_reg[`OCRS_SYSOSC_BYPASS_BIT];
  assign osc_range_choice = sysosc_reg[`OCRS_SYSOSC_RANGE_BIT];
  assign wdosc_div_code   = wddiv_reg;
  assign wdosc_freq_code  = wdfreq_reg;
  assign rc_osc_trim      = trim_reg;
  assign pll_src_sel      = applied_reg;
  assign prdata           = prdata_reg;

  // Divide ratio 2*(1+code): code 0 gives 2, code 31 gives 64
  // Built from the next code, so the ratio moves with the code itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdosc_div_ratio <= 7'h02;
    end else begin
      wdosc_div_ratio <= {1'b0, wddiv_next, 1'b0} + 7'h02;
    end
  end

endmodule : ocrs_top

// [rtl/ocrs_defines.svh]
`ifndef OCRS_DEFINES_SVH
`define OCRS_DEFINES_SVH

// Register byte addresses on the APB
`define OCRS_ADDR_SYSOSC   32'h4004_8020
`define OCRS_ADDR_WDOSC    32'h4004_8024
`define OCRS_ADDR_TRIM     32'h4004_8028
`define OCRS_ADDR_RSTCAUSE 32'h4004_8030
`define OCRS_ADDR_PLLSRC   32'h4004_8040
`define OCRS_ADDR_PLLUPD   32'h4004_8044
`define OCRS_ADDR_IRQSTAT  32'h4004_8050
`define OCRS_ADDR_IRQMASK  32'h4004_8054

// Field positions
`define OCRS_SYSOSC_BYPASS_BIT 0
`define OCRS_SYSOSC_RANGE_BIT  1
`define OCRS_WDOSC_DIV_LSB     0
`define OCRS_WDOSC_DIV_MSB     4
`define OCRS_WDOSC_FREQ_LSB    5
`define OCRS_WDOSC_FREQ_MSB    8
`define OCRS_UPD_BIT           0

// Reset cause bits
`define OCRS_RC_POR 0
`define OCRS_RC_PIN 1
`define OCRS_RC_WDT 2
`define OCRS_RC_BOD 3
`define OCRS_RC_SW  4

// Interrupt event bits
`define OCRS_EV_SWITCHED 0
`define OCRS_EV_RSTSEEN  1
`define OCRS_EV_RSVDSRC  2

// Reset values
`define OCRS_RST_SYSOSC   2'h0
`define OCRS_RST_WDDIV    5'h00
`define OCRS_RST_WDFREQ   4'h5
`define OCRS_RST_TRIM     8'h00
`define OCRS_RST_CAUSE    5'h01
`define OCRS_RST_PLLSRC   2'h0
`define OCRS_RST_UPD      1'h0
`define OCRS_RST_IRQ      3'h0

`endif

// [rtl/ocrs_pkg.sv]
package ocrs_pkg;

  // PLL input source code
  typedef logic [1:0] ocrs_pll_src_t;

  // Decoded register of an APB access
  typedef enum logic [3:0] {
    OCRS_R_NONE,
    OCRS_R_SYSOSC,
    OCRS_R_WDOSC,
    OCRS_R_TRIM,
    OCRS_R_RSTCAUSE,
    OCRS_R_PLLSRC,
    OCRS_R_PLLUPD,
    OCRS_R_IRQSTAT,
    OCRS_R_IRQMASK
  } ocrs_reg_e;

endpackage : ocrs_pkg

// [rtl/ocrs_sync.sv]
`timescale 1ns/1ns
module ocrs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Levels from another domain and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // Two flip-flop chain; the first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ocrs_sync

// [testbench/ocrs_top_assertions.sv]
`timescale 1ns/1ns
`include "ocrs_defines.svh"
module ocrs_top_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Oscillator controls, PLL source and interrupt
  input wire logic        osc_bypass,
  input wire logic        osc_range_choice,
  input wire logic [4:0]  wdosc_div_code,
  input wire logic [3:0]  wdosc_freq_code,
  input wire logic [6:0]  wdosc_div_ratio,
  input wire logic [7:0]  rc_osc_trim,
  input wire logic [1:0]  pll_src_sel,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Completed write and update strobe write
  wire logic wr   = psel && penable && pwrite && pready;
  wire logic upd1 = wr && paddr == `OCRS_ADDR_PLLUPD && pwdata[0];
  AST_RATIO: assert property (
    wdosc_div_ratio == 7'(2 * (wdosc_div_code + 1)))
    else $error("divider ratio wrong");
  AST_OSC_WR: assert property (
    wr && paddr == `OCRS_ADDR_SYSOSC |=>
    {osc_range_choice, osc_bypass} == $past(pwdata[1:0]))
    else $error("system osc bits wrong");
  AST_WD_WR: assert property (
    wr && paddr == `OCRS_ADDR_WDOSC |=>
    {wdosc_freq_code, wdosc_div_code} == $past(pwdata[8:0]))
    else $error("watchdog osc codes wrong");
  AST_TRIM_WR: assert property (
    wr && paddr == `OCRS_ADDR_TRIM |=> rc_osc_trim == $past(pwdata[7:0]))
    else $error("trim wrong");
  AST_SRC_HOLD: assert property (
    $changed(pll_src_sel) |-> $past(upd1, 2))
    else $error("source changed without update");
  AST_UPD_RD: assert property (
    psel && penable && !pwrite && paddr == `OCRS_ADDR_PLLUPD |->
    prdata[31:1] == 31'h0) else $error("update reserved bits set");
  AST_UNMAPPED: assert property (
    psel && penable && !pwrite && paddr == 32'h4004_8034 |->
    pslverr && prdata == 32'h0) else $error("unmapped read wrong");
  AST_RST_VAL: assert property (
    $fell(rst) |-> wdosc_freq_code == 4'h5 && pll_src_sel == 2'h0 && !irq)
    else $error("reset values wrong");
  // Main scenarios reached
  cover property (upd1);
  cover property ($changed(pll_src_sel));
  cover property ($rose(irq));
endmodule : ocrs_top_chk

bind ocrs_top ocrs_top_chk u_chk (.clock, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_bypass,
  .osc_range_choice, .wdosc_div_code, .wdosc_freq_code, .wdosc_div_ratio,
  .rc_osc_trim, .pll_src_sel, .irq);

// [testbench/test_ocrs_top.sv]
`timescale 1ns/1ns
`include "ocrs_defines.svh"
module test_ocrs_top;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic        pready, pslverr, err, osc_bypass, osc_range_choice, irq;
  logic [3:0]  srcv = '0, wdosc_freq_code;
  logic [4:0]  wdosc_div_code;
  logic [6:0]  wdosc_div_ratio;
  logic [7:0]  rc_osc_trim;
  logic [1:0]  pll_src_sel;
  int          n_mismatch = 0, compares = 0;

  // 20 MHz clock
  always #25 clock = ~clock;

  ocrs_top dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_reset_in(srcv[0]),
    .wdt_reset_in(srcv[1]), .bod_reset_in(srcv[2]), .sw_reset_in(srcv[3]),
    .osc_bypass, .osc_range_choice, .wdosc_div_code, .wdosc_freq_code,
    .wdosc_div_ratio, .rc_osc_trim, .pll_src_sel, .irq);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask : rd

  task automatic t_reset;
    rd(`OCRS_ADDR_SYSOSC, 32'h0);
    rd(`OCRS_ADDR_WDOSC, 32'hA0);
    rd(`OCRS_ADDR_RSTCAUSE, 32'h1);
    rd(`OCRS_ADDR_PLLSRC, 32'h0);
    rd(`OCRS_ADDR_PLLUPD, 32'h0);
    rd(32'h4004_8034, 32'h0);
    chk(32'(err), 32'h1);
    wr(32'h4004_8034, 32'hFFFF_FFFF);
    chk(32'(err), 32'h1);
    rd(`OCRS_ADDR_SYSOSC, 32'h0);
  endtask : t_reset

  task automatic t_osc;
    logic [4:0] dv[4] = '{5'h00, 5'h01, 5'h02, 5'h1F};
    logic [3:0] fv[4] = '{4'h1, 4'hF, 4'h5, 4'hA};
    wr(`OCRS_ADDR_SYSOSC, 32'hFFFF_FFFD);
    chk(32'({osc_range_choice, osc_bypass}), 32'h1);
    rd(`OCRS_ADDR_SYSOSC, 32'h1);
    wr(`OCRS_ADDR_SYSOSC, 32'h2);
    chk(32'({osc_range_choice, osc_bypass}), 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(`OCRS_ADDR_WDOSC, {23'h7FFFFF, fv[i], dv[i]});
      chk(32'(wdosc_div_ratio), 2 * (dv[i] + 1));
      chk(32'(wdosc_freq_code), 32'(fv[i]));
      rd(`OCRS_ADDR_WDOSC, {23'h0, fv[i], dv[i]});
    end
    wr(`OCRS_ADDR_TRIM, 32'hFFFF_FFA5);
    chk(32'(rc_osc_trim), 32'hA5);
    rd(`OCRS_ADDR_TRIM, 32'hA5);
  endtask : t_osc

  // Source switch sequence: code, update 0, update 1
  task automatic t_pll;
    logic [1:0] cv[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] prev = 2'h0;
    wr(`OCRS_ADDR_IRQMASK, 32'h1);
    rd(`OCRS_ADDR_IRQMASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`OCRS_ADDR_PLLSRC, {30'h3FFFFFFF, cv[i]});
      wr(`OCRS_ADDR_PLLUPD, 32'h0);
      chk(32'(pll_src_sel), 32'(prev));
      rd(`OCRS_ADDR_PLLSRC, 32'(cv[i]));
      wr(`OCRS_ADDR_PLLUPD, 32'h1);
      @(negedge clock);
      chk(32'(pll_src_sel), 32'(cv[i]));
      @(negedge clock);
      chk(32'(irq), 32'h1);
      rd(`OCRS_ADDR_IRQSTAT, (cv[i] == 2'h3) ? 32'h5 : 32'h1);
      wr(`OCRS_ADDR_IRQSTAT, 32'h7);
      @(negedge clock);
      chk(32'(irq), 32'h0);
      prev = cv[i];
    end
    wr(`OCRS_ADDR_PLLSRC, 32'h2);
    wr(`OCRS_ADDR_PLLUPD, 32'h1);
    repeat (3) @(negedge clock);
    chk(32'(pll_src_sel), 32'h0);
  endtask : t_pll

  task automatic t_cause;
    wr(`OCRS_ADDR_RSTCAUSE, 32'hFFFF_FFFF);
    rd(`OCRS_ADDR_RSTCAUSE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      srcv <= 4'(1 << i);
      repeat (4) @(posedge clock);
      srcv <= 4'h0;
      rd(`OCRS_ADDR_RSTCAUSE, 32'(2 << i));
      rd(`OCRS_ADDR_IRQSTAT, 32'h2);
      wr(`OCRS_ADDR_IRQSTAT, 32'h7);
      wr(`OCRS_ADDR_RSTCAUSE, 32'h1F);
      rd(`OCRS_ADDR_RSTCAUSE, 32'h0);
    end
    srcv <= 4'h4;
    repeat (4) @(posedge clock);
    srcv <= 4'h1;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    srcv <= 4'h0;
    rd(`OCRS_ADDR_RSTCAUSE, 32'h3);
  endtask : t_cause

  task automatic stop_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_osc();
    t_pll();
    t_cause();
    stop_test();
  end

  // Hang guard
  initial begin
    #(50 * 5000);
    n_mismatch++;
    stop_test();
  end
endmodule : test_ocrs_top
